// ==== verilog/sscf_defs.svh ====
`ifndef SSCF_DEFS_SVH
`define SSCF_DEFS_SVH

// Register byte offsets
`define SSCF_A_CTRL 8'h00
`define SSCF_A_CDIV 8'h04
`define SSCF_A_RCLK 8'h10
`define SSCF_A_RFRM 8'h14
`define SSCF_A_TCLK 8'h18
`define SSCF_A_TFRM 8'h1C
`define SSCF_A_RHLD 8'h20
`define SSCF_A_THLD 8'h24
`define SSCF_A_RSYN 8'h30
`define SSCF_A_TSYN 8'h34
`define SSCF_A_CMP0 8'h38
`define SSCF_A_CMP1 8'h3C
`define SSCF_A_STAT 8'h40
`define SSCF_A_IEN 8'h44
`define SSCF_A_IDIS 8'h48
`define SSCF_A_IMSK 8'h4C

// Control command bits
`define SSCF_C_SOFT_RESET_CMD 15
`define SSCF_C_TX_DISABLE_CMD 9
`define SSCF_C_TX_ENABLE_CMD 8
`define SSCF_C_RX_DISABLE_CMD 1
`define SSCF_C_RX_ENABLE_CMD 0

// Clock and frame configuration fields
`define SSCF_F_DIV 11:0
`define SSCF_F_CKS 1:0
`define SSCF_F_START 11:8
`define SSCF_F_DLY 23:16
`define SSCF_F_WL 4:0
`define SSCF_F_LVL 5
`define SSCF_F_MSB_FIRST_SEL 7
`define SSCF_F_WPF 11:8
`define SSCF_F_SYNC_LENGTH 20:16
`define SSCF_F_SYNC_DATA_SEND_EN 23

// Status bits
`define SSCF_S_TX_READY_FLAG 0
`define SSCF_S_TXEMP 1
`define SSCF_S_RXRDY 4
`define SSCF_S_OVR 5
`define SSCF_S_TXON 16
`define SSCF_S_RXON 17
`define SSCF_S_FIXED 32'h0000_00CC
`define SSCF_S_EVENTS 32'h0000_0033

// Start selections and clock selections
`define SSCF_ST_CONT 4'h0
`define SSCF_ST_TX 4'h1
`define SSCF_ST_LOW 4'h2
`define SSCF_ST_HIGH 4'h3
`define SSCF_ST_FALL 4'h4
`define SSCF_ST_RISE 4'h5
`define SSCF_ST_CHG 4'h6
`define SSCF_ST_EDGE 4'h7
`define SSCF_ST_CMP0 4'h8
`define SSCF_CKS_PIN 2'h2

`endif

// ==== verilog/sscf_pkg.sv ====
`include "sscf_defs.svh"

package sscf_pkg;

   typedef enum logic [1:0] {
      SSCF_IDLE = 2'b00,
      SSCF_SYNC = 2'b01,
      SSCF_DLY = 2'b10,
      SSCF_DATA = 2'b11
   } sscf_state_t;

   typedef struct packed {
      logic [4:0] wl;
      logic [3:0] wpf;
      logic msb_first_sel;
      logic [4:0] sync_length;
      logic lvl;
      logic sync_data_send_en;
      logic [3:0] start;
      logic [7:0] dly;
      logic [1:0] cks;
   } sscf_frame_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } sscf_apb_req_t;

endpackage

// ==== verilog/sscf_top.sv ====
// Design decision made here: the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "sscf_defs.svh"

// How it works
// - Transmitter and receiver each keep a separate clock and frame configuration.
// - Word length field gives one to thirty-two bits per word.
// - Words-per-frame field gives one to sixteen words per start event.
// - Sync length field moves up to sixteen sync bits through sync holders.
// - Start delay field inserts up to 255 bit periods before data.
// - Bit-order bit picks most or least significant bit first.
// - With sync send enabled, sync period shifts out the transmit sync holder.
// - Idle transmitter drives the data line at the idle level bit.
// - Continuous start never emits sync data; sync enable is ignored.
// - Loop mode feeds receiver data, sync and clock from the transmitter.
// - Writing ones to enable sets mask bits; to disable clears them.
// - Interrupt line rises when an unmasked status event is set.
// - Soft reset bit 15 resets the block and beats other bits.
// - Transmit disable bit 9 stops after the current word completes.
// - Transmit enable bit 8 enables unless bit 9 also written.
// - Receive disable bit 1 stops after the current word completes.
// - Receive enable bit 0 enables unless bit 1 also written.
// - Divider zero stops the bit clock, else clock divided by twice it.
// - Receive start codes 0 to 8 decoded, higher codes never start.
// - Ready flag when holder moves to shifter, empty when both empty.
module sscf_top (
   input wire logic REF_CLK,
   input wire logic RESET,
   input wire sscf_pkg::sscf_apb_req_t APB_REQ,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   output logic IRQ,
   output logic TX_DATA,
   output logic TX_FRAME_SYNC,
   output logic TX_CLOCK,
   input wire logic RX_DATA,
   input wire logic RX_FRAME_SYNC,
   input wire logic RX_CLOCK
);
   import sscf_pkg::*;

   typedef struct packed {
      logic apb_rdy;
      logic apb_err;
      logic [31:0] prdata;
      logic irq;
      logic [11:0] div;
      logic [31:0] rclk;
      logic [31:0] rfrm;
      logic [31:0] tclk;
      logic [31:0] tfrm;
      logic [31:0] rhld;
      logic [31:0] thld;
      logic [15:0] rsyn;
      logic [15:0] tsyn;
      logic [31:0] cmp0;
      logic [31:0] cmp1;
      logic [31:0] imsk;
      logic thr_full;
      logic rx_rdy;
      logic ovr;
      logic tx_en;
      logic tx_dpend;
      logic rx_en;
      logic rx_dpend;
      logic [11:0] cdiv_cnt;
      logic sclk;
      sscf_state_t tx_st;
      logic [4:0] tx_bit;
      logic [3:0] tx_word;
      logic [7:0] tx_dly;
      logic [31:0] tx_sh;
      logic tx_data;
      logic tx_fs;
      logic tx_seen;
      logic [2:0] rd_s;
      logic [2:0] rf_s;
      logic [2:0] rc_s;
      logic rd_f;
      logic rf_f;
      logic rc_f;
      logic rc_prev;
      logic rfs_prev;
      sscf_state_t rx_st;
      logic [4:0] rx_bit;
      logic [3:0] rx_word;
      logic [7:0] rx_dly;
      logic [31:0] rx_sh;
      logic [15:0] rx_sy;
      logic [15:0] cmp_sh;
   } sscf_regs_t;

   sscf_regs_t st_ff;
   sscf_regs_t nxt_st;
   sscf_frame_t tf;
   sscf_frame_t rf;
   logic rx_loop;
   logic tick;
   logic tx_edge;
   logic int_rise;
   logic rx_edge;
   logic rx_din;
   logic rx_fsin;
   logic rx_go;
   logic tx_go;
   logic tx_cont;
   logic tx_load;
   logic rx_load;
   logic [4:0] tidx;
   logic [4:0] ridx;
   logic [31:0] rx_new;
   logic [15:0] sy_new;
   logic [15:0] cmp_new;
   logic [15:0] cmp_mask;
   logic [31:0] status;
   logic [31:0] rd_val;
   logic rd_hit;
   logic acc_done;
   logic wr_done;
   logic rd_done;
   logic [31:0] wd;

   // Field decode, each direction from its own pair of registers
   always_comb begin
      tf.wl = st_ff.tfrm[`SSCF_F_WL];
      tf.wpf = st_ff.tfrm[`SSCF_F_WPF];
      tf.msb_first_sel = st_ff.tfrm[`SSCF_F_MSB_FIRST_SEL];
      tf.sync_length = (st_ff.tfrm[`SSCF_F_SYNC_LENGTH] > 5'h10) ? 5'h10 : st_ff.tfrm[`SSCF_F_SYNC_LENGTH];
      tf.lvl = st_ff.tfrm[`SSCF_F_LVL];
      tf.sync_data_send_en = st_ff.tfrm[`SSCF_F_SYNC_DATA_SEND_EN];
      tf.start = st_ff.tclk[`SSCF_F_START];
      tf.dly = st_ff.tclk[`SSCF_F_DLY];
      tf.cks = st_ff.tclk[`SSCF_F_CKS];
      rf.wl = st_ff.rfrm[`SSCF_F_WL];
      rf.wpf = st_ff.rfrm[`SSCF_F_WPF];
      rf.msb_first_sel = st_ff.rfrm[`SSCF_F_MSB_FIRST_SEL];
      rf.sync_length = (st_ff.rfrm[`SSCF_F_SYNC_LENGTH] > 5'h10) ? 5'h10 : st_ff.rfrm[`SSCF_F_SYNC_LENGTH];
      rf.lvl = st_ff.rfrm[`SSCF_F_LVL];
      rf.sync_data_send_en = st_ff.rfrm[`SSCF_F_SYNC_DATA_SEND_EN];
      rf.start = st_ff.rclk[`SSCF_F_START];
      rf.dly = st_ff.rclk[`SSCF_F_DLY];
      rf.cks = st_ff.rclk[`SSCF_F_CKS];
   end

   always_comb begin
      nxt_st = st_ff;
      rx_loop = rf.lvl;
      tx_load = 1'b0;
      rx_load = 1'b0;
      tx_go = 1'b0;
      rx_go = 1'b0;
      wd = APB_REQ.pwdata;

      // Bit clock divider
      tick = (st_ff.div != 12'h000) && (st_ff.cdiv_cnt == st_ff.div - 12'h001);
      if (st_ff.div == 12'h000) begin
         nxt_st.cdiv_cnt = 12'h000;
         nxt_st.sclk = 1'b0;
      end else if (tick) begin
         nxt_st.cdiv_cnt = 12'h000;
         nxt_st.sclk = !st_ff.sclk;
      end else begin
         nxt_st.cdiv_cnt = st_ff.cdiv_cnt + 12'h001;
      end
      tx_edge = tick && st_ff.sclk;
      int_rise = tick && !st_ff.sclk;

      // Pin synchronisers, a change counts when stages two and three agree
      nxt_st.rd_s = {st_ff.rd_s[1:0], RX_DATA};
      nxt_st.rf_s = {st_ff.rf_s[1:0], RX_FRAME_SYNC};
      nxt_st.rc_s = {st_ff.rc_s[1:0], RX_CLOCK};
      nxt_st.rd_f = (st_ff.rd_s[1] == st_ff.rd_s[2]) ? st_ff.rd_s[2] : st_ff.rd_f;
      nxt_st.rf_f = (st_ff.rf_s[1] == st_ff.rf_s[2]) ? st_ff.rf_s[2] : st_ff.rf_f;
      nxt_st.rc_f = (st_ff.rc_s[1] == st_ff.rc_s[2]) ? st_ff.rc_s[2] : st_ff.rc_f;
      nxt_st.rc_prev = st_ff.rc_f;

      // Receiver sources
      if (rx_loop) begin
         rx_edge = int_rise;
         rx_din = st_ff.tx_data;
         rx_fsin = st_ff.tx_fs;
      end else begin
         rx_edge = (rf.cks == `SSCF_CKS_PIN) ? (st_ff.rc_f && !st_ff.rc_prev) : int_rise;
         rx_din = st_ff.rd_f;
         rx_fsin = st_ff.rf_f;
      end

      // Transmitter, data changes on the falling bit clock edge
      tx_cont = (tf.start == `SSCF_ST_CONT);
      tidx = tf.msb_first_sel ? st_ff.tx_bit : 5'(tf.wl - st_ff.tx_bit);
      if (tx_edge) begin
         case (st_ff.tx_st)
            SSCF_IDLE: begin
               nxt_st.tx_data = tf.lvl;
               nxt_st.tx_fs = 1'b0;
               if (st_ff.tx_en && st_ff.thr_full && !st_ff.tx_dpend) begin
                  tx_go = 1'b1;
                  nxt_st.tx_word = 4'h0;
                  if (!tx_cont && tf.sync_length != 5'h00) begin
                     nxt_st.tx_st = SSCF_SYNC;
                     nxt_st.tx_bit = tf.sync_length - 5'h01;
                  end else if (tf.dly != 8'h00) begin
                     nxt_st.tx_st = SSCF_DLY;
                     nxt_st.tx_dly = tf.dly;
                  end else begin
                     tx_load = 1'b1;
                  end
               end
            end
            SSCF_SYNC: begin
               nxt_st.tx_fs = 1'b1;
               nxt_st.tx_data = tf.sync_data_send_en ? st_ff.tsyn[st_ff.tx_bit[3:0]] : tf.lvl;
               if (st_ff.tx_bit != 5'h00) begin
                  nxt_st.tx_bit = st_ff.tx_bit - 5'h01;
               end else if (tf.dly != 8'h00) begin
                  nxt_st.tx_st = SSCF_DLY;
                  nxt_st.tx_dly = tf.dly;
               end else begin
                  tx_load = 1'b1;
               end
            end
            SSCF_DLY: begin
               nxt_st.tx_fs = 1'b0;
               nxt_st.tx_data = tf.lvl;
               nxt_st.tx_dly = st_ff.tx_dly - 8'h01;
               if (st_ff.tx_dly <= 8'h01) begin
                  tx_load = 1'b1;
               end
            end
            SSCF_DATA: begin
               nxt_st.tx_fs = 1'b0;
               nxt_st.tx_data = st_ff.tx_sh[tidx];
               if (st_ff.tx_bit != 5'h00) begin
                  nxt_st.tx_bit = st_ff.tx_bit - 5'h01;
               end else if (st_ff.tx_dpend) begin
                  nxt_st.tx_en = 1'b0;
                  nxt_st.tx_dpend = 1'b0;
                  nxt_st.tx_st = SSCF_IDLE;
               end else if ((tx_cont || st_ff.tx_word != tf.wpf) && st_ff.thr_full) begin
                  tx_load = 1'b1;
                  nxt_st.tx_word = st_ff.tx_word + 4'h1;
               end else begin
                  nxt_st.tx_st = SSCF_IDLE;
               end
            end
            default: nxt_st.tx_st = SSCF_IDLE;
         endcase
      end
      if (st_ff.tx_st == SSCF_IDLE && st_ff.tx_dpend) begin
         nxt_st.tx_en = 1'b0;
         nxt_st.tx_dpend = 1'b0;
      end
      if (tx_load) begin
         nxt_st.tx_sh = st_ff.thld;
         nxt_st.thr_full = 1'b0;
         nxt_st.tx_bit = tf.wl;
         nxt_st.tx_st = SSCF_DATA;
      end

      // Receiver, samples on the rising bit clock edge
      ridx = rf.msb_first_sel ? st_ff.rx_bit : 5'(rf.wl - st_ff.rx_bit);
      rx_new = st_ff.rx_sh;
      rx_new[ridx] = rx_din;
      sy_new = st_ff.rx_sy;
      sy_new[st_ff.rx_bit[3:0]] = rx_din;
      cmp_new = {st_ff.cmp_sh[14:0], rx_din};
      cmp_mask = 16'((17'h0_0001 << rf.sync_length) - 17'h0_0001);
      if (tx_go) begin
         nxt_st.tx_seen = 1'b1;
      end else if (rx_edge) begin
         nxt_st.tx_seen = 1'b0;
      end
      if (rx_edge) begin
         nxt_st.rfs_prev = rx_fsin;
         nxt_st.cmp_sh = cmp_new;
         case (st_ff.rx_st)
            SSCF_IDLE: begin
               if (st_ff.rx_en && !st_ff.rx_dpend) begin
                  case (rf.start)
                     `SSCF_ST_CONT: rx_go = 1'b1;
                     `SSCF_ST_TX: rx_go = st_ff.tx_seen;
                     `SSCF_ST_LOW: rx_go = !rx_fsin;
                     `SSCF_ST_HIGH: rx_go = rx_fsin;
                     `SSCF_ST_FALL: rx_go = st_ff.rfs_prev && !rx_fsin;
                     `SSCF_ST_RISE: rx_go = !st_ff.rfs_prev && rx_fsin;
                     `SSCF_ST_CHG: rx_go = st_ff.rfs_prev != rx_fsin;
                     `SSCF_ST_EDGE: rx_go = st_ff.rfs_prev != rx_fsin;
                     `SSCF_ST_CMP0: begin
                        rx_go = (rf.sync_length != 5'h00) &&
                           (((cmp_new ^ st_ff.cmp0[15:0]) & cmp_mask) == 16'h0000);
                     end
                     default: rx_go = 1'b0;
                  endcase
               end
               if (rx_go) begin
                  nxt_st.rx_word = 4'h0;
                  nxt_st.rx_sy = 16'h0000;
                  if (rf.start != `SSCF_ST_CONT && rf.start != `SSCF_ST_CMP0 &&
                      rf.sync_length != 5'h00) begin
                     nxt_st.rx_st = SSCF_SYNC;
                     nxt_st.rx_bit = rf.sync_length - 5'h01;
                  end else if (rf.dly != 8'h00) begin
                     nxt_st.rx_st = SSCF_DLY;
                     nxt_st.rx_dly = rf.dly;
                  end else begin
                     rx_load = 1'b1;
                  end
               end
            end
            SSCF_SYNC: begin
               nxt_st.rx_sy = sy_new;
               if (st_ff.rx_bit != 5'h00) begin
                  nxt_st.rx_bit = st_ff.rx_bit - 5'h01;
               end else begin
                  nxt_st.rsyn = sy_new;
                  if (rf.dly != 8'h00) begin
                     nxt_st.rx_st = SSCF_DLY;
                     nxt_st.rx_dly = rf.dly;
                  end else begin
                     rx_load = 1'b1;
                  end
               end
            end
            SSCF_DLY: begin
               nxt_st.rx_dly = st_ff.rx_dly - 8'h01;
               if (st_ff.rx_dly <= 8'h01) begin
                  rx_load = 1'b1;
               end
            end
            SSCF_DATA: begin
               nxt_st.rx_sh = rx_new;
               if (st_ff.rx_bit != 5'h00) begin
                  nxt_st.rx_bit = st_ff.rx_bit - 5'h01;
               end else begin
                  nxt_st.rhld = rx_new;
                  nxt_st.rx_rdy = 1'b1;
                  if (st_ff.rx_rdy) begin
                     nxt_st.ovr = 1'b1;
                  end
                  if (st_ff.rx_dpend) begin
                     nxt_st.rx_en = 1'b0;
                     nxt_st.rx_dpend = 1'b0;
                     nxt_st.rx_st = SSCF_IDLE;
                  end else if (rf.start == `SSCF_ST_CONT || st_ff.rx_word != rf.wpf) begin
                     rx_load = 1'b1;
                     nxt_st.rx_word = st_ff.rx_word + 4'h1;
                  end else begin
                     nxt_st.rx_st = SSCF_IDLE;
                  end
               end
            end
            default: nxt_st.rx_st = SSCF_IDLE;
         endcase
      end
      if (st_ff.rx_st == SSCF_IDLE && st_ff.rx_dpend) begin
         nxt_st.rx_en = 1'b0;
         nxt_st.rx_dpend = 1'b0;
      end
      if (rx_load) begin
         nxt_st.rx_sh = 32'h0000_0000;
         nxt_st.rx_bit = rf.wl;
         nxt_st.rx_st = SSCF_DATA;
      end

      // Status word and register read
      status = `SSCF_S_FIXED;
      status[`SSCF_S_TX_READY_FLAG] = st_ff.tx_en && !st_ff.thr_full;
      status[`SSCF_S_TXEMP] = st_ff.tx_en && !st_ff.thr_full && st_ff.tx_st == SSCF_IDLE;
      status[`SSCF_S_RXRDY] = st_ff.rx_rdy;
      status[`SSCF_S_OVR] = st_ff.ovr;
      status[`SSCF_S_TXON] = st_ff.tx_en;
      status[`SSCF_S_RXON] = st_ff.rx_en;
      rd_hit = 1'b1;
      case (APB_REQ.paddr)
         `SSCF_A_CTRL: rd_val = 32'h0000_0000;
         `SSCF_A_CDIV: rd_val = {20'h0_0000, st_ff.div};
         `SSCF_A_RCLK: rd_val = st_ff.rclk;
         `SSCF_A_RFRM: rd_val = st_ff.rfrm;
         `SSCF_A_TCLK: rd_val = st_ff.tclk;
         `SSCF_A_TFRM: rd_val = st_ff.tfrm;
         `SSCF_A_RHLD: rd_val = st_ff.rhld;
         `SSCF_A_THLD: rd_val = 32'h0000_0000;
         `SSCF_A_RSYN: rd_val = {16'h0000, st_ff.rsyn};
         `SSCF_A_TSYN: rd_val = {16'h0000, st_ff.tsyn};
         `SSCF_A_CMP0: rd_val = st_ff.cmp0;
         `SSCF_A_CMP1: rd_val = st_ff.cmp1;
         `SSCF_A_STAT: rd_val = status;
         `SSCF_A_IEN: rd_val = 32'h0000_0000;
         `SSCF_A_IDIS: rd_val = 32'h0000_0000;
         `SSCF_A_IMSK: rd_val = st_ff.imsk;
         default: begin
            rd_val = 32'h0000_0000;
            rd_hit = 1'b0;
         end
      endcase

      // APB slave, one wait state then completion
      acc_done = APB_REQ.psel && APB_REQ.penable && st_ff.apb_rdy;
      wr_done = acc_done && APB_REQ.pwrite && !st_ff.apb_err;
      rd_done = acc_done && !APB_REQ.pwrite && !st_ff.apb_err;
      if (APB_REQ.psel && APB_REQ.penable && !st_ff.apb_rdy) begin
         nxt_st.apb_rdy = 1'b1;
         nxt_st.apb_err = !rd_hit;
         nxt_st.prdata = APB_REQ.pwrite ? 32'h0000_0000 : rd_val;
      end else begin
         nxt_st.apb_rdy = 1'b0;
         nxt_st.apb_err = 1'b0;
      end
      if (rd_done && APB_REQ.paddr == `SSCF_A_RHLD && !(rx_edge && nxt_st.rx_rdy && !st_ff.rx_rdy)) begin
         nxt_st.rx_rdy = nxt_st.rx_rdy && (rx_edge && st_ff.rx_st == SSCF_DATA &&
            st_ff.rx_bit == 5'h00);
      end
      if (rd_done && APB_REQ.paddr == `SSCF_A_STAT) begin
         nxt_st.ovr = rx_edge && st_ff.rx_st == SSCF_DATA && st_ff.rx_bit == 5'h00 &&
            st_ff.rx_rdy;
      end
      if (wr_done) begin
         case (APB_REQ.paddr)
            `SSCF_A_CTRL: begin
               if (wd[`SSCF_C_TX_DISABLE_CMD]) begin
                  nxt_st.tx_dpend = st_ff.tx_en;
               end else if (wd[`SSCF_C_TX_ENABLE_CMD]) begin
                  nxt_st.tx_en = 1'b1;
                  nxt_st.tx_dpend = 1'b0;
               end
               if (wd[`SSCF_C_RX_DISABLE_CMD]) begin
                  nxt_st.rx_dpend = st_ff.rx_en;
               end else if (wd[`SSCF_C_RX_ENABLE_CMD]) begin
                  nxt_st.rx_en = 1'b1;
                  nxt_st.rx_dpend = 1'b0;
               end
            end
            `SSCF_A_CDIV: nxt_st.div = wd[`SSCF_F_DIV];
            `SSCF_A_RCLK: nxt_st.rclk = wd;
            `SSCF_A_RFRM: nxt_st.rfrm = wd;
            `SSCF_A_TCLK: nxt_st.tclk = wd;
            `SSCF_A_TFRM: nxt_st.tfrm = wd;
            `SSCF_A_THLD: begin
               nxt_st.thld = wd;
               nxt_st.thr_full = 1'b1;
            end
            `SSCF_A_TSYN: nxt_st.tsyn = wd[15:0];
            `SSCF_A_CMP0: nxt_st.cmp0 = wd;
            `SSCF_A_CMP1: nxt_st.cmp1 = wd;
            `SSCF_A_IEN: nxt_st.imsk = st_ff.imsk | (wd & `SSCF_S_EVENTS);
            `SSCF_A_IDIS: nxt_st.imsk = st_ff.imsk & ~wd;
            default: nxt_st.imsk = nxt_st.imsk;
         endcase
      end

      nxt_st.irq = |(status & st_ff.imsk & `SSCF_S_EVENTS);

      // Soft reset clears everything, the bus ready flag included
      if (wr_done && APB_REQ.paddr == `SSCF_A_CTRL && wd[`SSCF_C_SOFT_RESET_CMD]) begin
         nxt_st = '0;
         nxt_st.apb_rdy = 1'b0;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign PRDATA = st_ff.prdata;
   assign PREADY = st_ff.apb_rdy;
   assign PSLVERR = st_ff.apb_err;
   assign IRQ = st_ff.irq;
   assign TX_DATA = st_ff.tx_data;
   assign TX_FRAME_SYNC = st_ff.tx_fs;
   assign TX_CLOCK = st_ff.sclk;

endmodule

`default_nettype wire

// ==== tb/sscf_checker_properties.sv ====
`timescale 1ns/10ps
`default_nettype none
module sscf_checker (
   input wire logic REF_CLK,
   input wire logic RESET,
   input wire sscf_pkg::sscf_apb_req_t APB_REQ,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire logic IRQ,
   input wire logic TX_DATA,
   input wire logic TX_FRAME_SYNC,
   input wire logic TX_CLOCK
);
   import sscf_pkg::*;
   logic [31:0] mask_ff;
   logic [11:0] cdiv_ff;
   logic wdone;
   logic rdone;
   assign wdone = PREADY && APB_REQ.psel && APB_REQ.penable && APB_REQ.pwrite;
   assign rdone = PREADY && !APB_REQ.pwrite;
   // Shadow of the mask and divider as software wrote them
   always_ff @(posedge REF_CLK) begin
      if (RESET || (wdone && APB_REQ.paddr == 8'h00 && APB_REQ.pwdata[15])) begin
         mask_ff <= '0;
         cdiv_ff <= '0;
      end else if (wdone) begin
         if (APB_REQ.paddr == 8'h44) mask_ff <= mask_ff | APB_REQ.pwdata;
         if (APB_REQ.paddr == 8'h48) mask_ff <= mask_ff & ~APB_REQ.pwdata;
         if (APB_REQ.paddr == 8'h04) cdiv_ff <= APB_REQ.pwdata[11:0];
      end
   end
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (RESET);
   pready_wait_a: assert property (APB_REQ.psel && APB_REQ.penable && !PREADY |=> PREADY)
      else $error("ready not one cycle after access");
   pready_pulse_a: assert property (PREADY |=> !PREADY)
      else $error("ready longer than one cycle");
   pready_req_a: assert property (PREADY |-> APB_REQ.psel && APB_REQ.penable)
      else $error("ready without access");
   slverr_map_a: assert property (PREADY |-> PSLVERR == !(APB_REQ.paddr[1:0] == 2'b00 &&
      APB_REQ.paddr inside {8'h00, 8'h04, [8'h10:8'h24], [8'h30:8'h4C]}))
      else $error("error flag wrong for address");
   wo_read_a: assert property (rdone && APB_REQ.paddr inside {8'h00, 8'h24, 8'h44, 8'h48}
      |-> PRDATA == 32'h0) else $error("write-only register read nonzero");
   mask_view_a: assert property (rdone && APB_REQ.paddr == 8'h4C |->
      (PRDATA & 32'h33) == (mask_ff & 32'h33)) else $error("mask view wrong");
   irq_masked_a: assert property (IRQ |-> ((mask_ff | $past(mask_ff)) & 32'h33) != 0)
      else $error("interrupt with empty mask");
   soft_reset_cmd_quiet_a: assert property (wdone && APB_REQ.paddr == 8'h00 && APB_REQ.pwdata[15]
      |=> !IRQ && !TX_CLOCK && !TX_FRAME_SYNC && !TX_DATA && !PREADY)
      else $error("outputs active after soft reset");
   div_zero_a: assert property ((cdiv_ff == 12'h0)[*3] |-> !TX_CLOCK)
      else $error("bit clock runs with divider zero");
   div_half_a: assert property ($rose(TX_CLOCK) && cdiv_ff == 12'h002 |=>
      TX_CLOCK ##1 !TX_CLOCK) else $error("bit clock half period not two cycles");
endmodule
`default_nettype wire

// ==== tb/sscf_codec_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module sscf_codec_model (
   input wire logic clk,
   input wire logic tx_data,
   input wire logic tx_sync,
   input wire logic tx_clock,
   output logic rx_data,
   output logic rx_sync,
   output logic rx_clock
);
   // Codec strapped for echo: returns the link one clock late
   initial begin
      rx_data = 1'b0;
      rx_sync = 1'b0;
      rx_clock = 1'b0;
   end
   always @(posedge clk) begin
      rx_data <= tx_data;
      rx_sync <= tx_sync;
      rx_clock <= tx_clock;
   end
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import sscf_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   sscf_apb_req_t req = '0;
   logic [31:0] prdata;
   logic pready, pslverr, irq, txd, txs, txc, rxd, rxs, rxc;
   int failures = 0;
   int n_tests = 0;
   logic [7:0] cfg_a [8] = '{8'h04, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h34, 8'h38, 8'h3C};
   logic [31:0] cfg_v [8] = '{32'h0000_0ABC, 32'h00FF_0800, 32'h009F_0F9F, 32'h0012_0100,
      32'h0085_031F, 32'h0000_A5C3, 32'h0000_1234, 32'h0000_4321};
   always #12.5 clk = ~clk;
   sscf_top i_dut (.REF_CLK(clk), .RESET(rst), .APB_REQ(req), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .IRQ(irq), .TX_DATA(txd), .TX_FRAME_SYNC(txs), .TX_CLOCK(txc),
      .RX_DATA(rxd), .RX_FRAME_SYNC(rxs), .RX_CLOCK(rxc));
   sscf_codec_model i_codec (.clk(clk), .tx_data(txd), .tx_sync(txs), .tx_clock(txc),
      .rx_data(rxd), .rx_sync(rxs), .rx_clock(rxc));
   task finish_test;
      $display("Comparisons %0d, mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
      output logic e);
      int n;
      @(posedge clk);
      req <= '{1'b1, 1'b0, w, a, d};
      @(posedge clk);
      req.penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         failures++;
         finish_test();
      end
      r = prdata;
      e = pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      chk($sformatf("reg %h", a), exp, r);
   endtask
   task t_regs;
      logic [31:0] r;
      logic e;
      rd(8'h40, 32'h0000_00CC);
      for (int i = 0; i < 8; i++) begin
         rd(cfg_a[i], 32'h0);
         wr(cfg_a[i], cfg_v[i]);
         rd(cfg_a[i], cfg_v[i]);
      end
      for (int c = 0; c < 9; c++) begin
         wr(8'h10, {20'h0, c[3:0], 8'h0});
         rd(8'h10, {20'h0, c[3:0], 8'h0});
      end
      wr(8'h20, 32'hFFFF_FFFF);
      rd(8'h20, 32'h0);
      rd(8'h24, 32'h0);
      apb(1'b0, 8'h08, 32'h0, r, e);
      chk("unmapped error", 32'h1, {31'h0, e});
   endtask
   task t_soft_reset_cmd;
      wr(8'h44, 32'h0000_0033);
      wr(8'h00, 32'h0000_8101);
      rd(8'h04, 32'h0);
      rd(8'h4C, 32'h0);
      rd(8'h40, 32'h0000_00CC);
   endtask
   task t_ctrl;
      wr(8'h00, 32'h0000_0303);
      rd(8'h40, 32'h0000_00CC);
      wr(8'h00, 32'h0000_0101);
      rd(8'h40, 32'h0003_00CF);
      wr(8'h00, 32'h0000_0000);
      rd(8'h40, 32'h0003_00CF);
      wr(8'h00, 32'h0000_0002);
      rd(8'h40, 32'h0001_00CF);
   endtask
   task t_tx(input logic msb);
      logic [7:0] got, rv;
      logic pc, fs;
      int k, n;
      rv = {<<{8'hB3}};
      wr(8'h04, 32'h0000_0002);
      wr(8'h1C, {8'h00, 8'h84, 8'h00, msb, 7'h07});
      wr(8'h24, 32'h0000_00B3);
      k = 0;
      n = 0;
      pc = 1'b1;
      fs = 1'b0;
      while (k < 8 && n < 2000) begin
         @(negedge clk);
         n++;
         fs = fs | txs;
         if (txc && !pc && (k > 0 || txd)) begin
            got = {got[6:0], txd};
            k++;
         end
         pc = txc;
      end
      if (k < 8) begin
         failures++;
         finish_test();
      end
      chk("tx word", msb ? 32'hB3 : {24'h0, rv}, {24'h0, got});
      chk("cont sync", 32'h0, {31'h0, fs});
      repeat (40) @(negedge clk);
      chk("idle level", 32'h0, {31'h0, txd});
      rd(8'h40, 32'h0001_00CF);
      wr(8'h1C, 32'h0000_0027);
      repeat (6) @(negedge clk);
      chk("idle level", 32'h1, {31'h0, txd});
   endtask
   task t_irq;
      wr(8'h44, 32'h0000_0020);
      repeat (3) @(negedge clk);
      chk("irq", 32'h0, {31'h0, irq});
      wr(8'h44, 32'h0000_0001);
      rd(8'h4C, 32'h0000_0021);
      @(negedge clk);
      chk("irq", 32'h1, {31'h0, irq});
      wr(8'h48, 32'h0000_0021);
      rd(8'h4C, 32'h0);
      @(negedge clk);
      chk("irq", 32'h0, {31'h0, irq});
   endtask
   task t_loop;
      wr(8'h14, 32'h0000_00A7);
      wr(8'h10, 32'h0000_0100);
      wr(8'h1C, 32'h0000_0087);
      wr(8'h00, 32'h0000_0001);
      wr(8'h24, 32'h0000_00B3);
      repeat (60) @(negedge clk);
      rd(8'h40, 32'h0003_00DF);
      rd(8'h20, 32'h0000_00B3);
      rd(8'h40, 32'h0003_00CF);
   endtask
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_soft_reset_cmd();
      t_ctrl();
      t_tx(1'b1);
      t_tx(1'b0);
      t_irq();
      t_loop();
      finish_test();
   end
endmodule
bind sscf_top sscf_checker i_chk (.REF_CLK(REF_CLK), .RESET(RESET), .APB_REQ(APB_REQ),
   .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .IRQ(IRQ), .TX_DATA(TX_DATA),
   .TX_FRAME_SYNC(TX_FRAME_SYNC), .TX_CLOCK(TX_CLOCK));
`default_nettype wire
